// File: src/fpc_cache.v
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_map.vh"

// Overview of operation
// - sixteen fully associative lines of 128 bits each
// - flash is always addressed on 16-byte boundaries, low four bits zero
// - a miss fills a whole line chosen by pseudo-LRU
// - miss waits programmed flash wait states; hit answers with no wait states
// - hit counter counts cacheable fetch or load hits only
// - miss counter counts cacheable instruction fetch misses only
// - abort counter counts prefetches dropped by jump, load or store
// - pseudo-LRU state readable as 25 bits, upper bits read zero
// - allocation field reserves none, line 15, lines 14-15 or 12-15 for data
// - prefetch field enables fetching the next 16-byte block ahead
// - a line is locked only when valid and lock are both set
// - lines 10 and 11 alone apply the mask to force bit matches
// - masked hit answers at once and starts prefetch of next block
// - tag writes to indexed line only while tag write enable is set
// - tag write of valid zero with lock one requests a preload
// - preload acknowledged next cycle, prefetch stopped, processor stalled
// - preload reads flash at tag address after wait states into line
// - preload completion sets valid and leaves replacement order alone
// - stalled requests then resume; a miss pays full flash time
// - uncacheable accesses bypass the cache and always read flash
// - miss fill replaces an eligible line of least recently used quarter, else the lowest-numbered eligible line
// - reset invalidates, unlocks, marks instruction, clears masks, orders lines
module fpc_cache (
	input  wire         ref_clk,
	input  wire         rst_n,
	input  wire [7:0]   regAddr,
	input  wire [31:0]  regWdata,
	input  wire         regWr,
	input  wire         regRd,
	output reg  [31:0]  regRdata,
	input  wire         cpuReq,
	input  wire [31:0]  cpuAddr,
	input  wire         cpuFetch,
	input  wire         cpuCacheable,
	input  wire         cpuStore,
	output reg          cpuAck,
	output reg  [31:0]  cpuRdata,
	output wire         cpuStall,
	output reg          preloadAck,
	output reg          flashReq,
	output reg  [31:0]  flashAddr,
	input  wire [127:0] flashRdata
);

	localparam [1:0] ST_IDLE  = 2'b01;
	localparam [1:0] ST_FLASH = 2'b10;

	reg [2:0]   waitQ;
	reg [1:0]   prefEnQ;
	reg [1:0]   dcszQ;
	reg [3:0]   accIdxQ;
	reg         tagWenQ;
	reg [127:0] lineData [0:15];
	reg [19:0]  lineTag  [0:15];
	reg [15:0]  validQ;
	reg [15:0]  lockQ;
	reg [15:0]  typeQ;
	reg [10:0]  maskAQ;
	reg [10:0]  maskBQ;
	reg [24:0]  lruQ;
	reg [31:0]  hitCntQ;
	reg [31:0]  missCntQ;
	reg [31:0]  abtCntQ;
	reg [1:0]   stateQ;
	reg [1:0]   kindQ;
	reg [2:0]   cntQ;
	reg         preloadPendQ;
	reg [3:0]   plIdxQ;
	reg         pfValidQ;
	reg [27:0]  pfBlockQ;
	reg [127:0] pfDataQ;
	reg         pfStartQ;
	reg [27:0]  pfNextQ;

	reg [15:0]  hitVec;
	reg [15:0]  resvVec;
	reg [15:0]  eligVec;
	reg [1:0]   oldGrp;
	reg [2:0]   grpTree;
	reg [3:0]   prefVic;
	reg [4:0]   grpPick;
	reg [4:0]   anyPick;
	reg         vicAny;
	reg [3:0]   vicIdx;
	integer     n;
	integer     r;

	wire [4:0]  hitEnc   = firstOne(hitVec);
	wire        hitAny   = hitEnc[4];
	wire [3:0]  hitIdx   = hitEnc[3:0];
	wire [27:0] cpuBlock = cpuAddr[31:4];
	wire        accept   = cpuReq & ~cpuAck & ~preloadPendQ;
	wire        prefOn   = (prefEnQ != 2'b00);
	wire        pfBusy   = (stateQ == ST_FLASH) && (kindQ == `FPC_K_PREF);

	assign cpuStall = preloadPendQ;

	function lineHit;
		input [19:0] tag;
		input [19:0] a;
		input [10:0] m;
		begin
			lineHit = (((tag ^ a) & ~{8'h00, m, 1'b0}) == 20'h00000);
		end
	endfunction

	function [4:0] firstOne;
		input [15:0] v;
		integer k;
		begin
			firstOne = 5'h00;
			for (k = 15; k >= 0; k = k - 1) begin
				if (v[k])
					firstOne = {1'b1, k[3:0]};
			end
		end
	endfunction

	function [31:0] wordOf;
		input [127:0] d;
		input [1:0]   s;
		begin
			wordOf = d[s*32 +: 32];
		end
	endfunction

	// group age matrix in bits 5:0 (set = lower group older), tree per group above
	function [24:0] touchLru;
		input [24:0] s;
		input [3:0]  l;
		integer i;
		integer j;
		integer k;
		reg [1:0] g;
		begin
			touchLru = s;
			g = l[3:2];
			k = 0;
			for (i = 0; i < 3; i = i + 1) begin
				for (j = i + 1; j < 4; j = j + 1) begin
					if (g == i[1:0])
						touchLru[k] = 1'b0;
					else if (g == j[1:0])
						touchLru[k] = 1'b1;
					k = k + 1;
				end
			end
			touchLru[6 + 3*g] = ~l[1];
			if (!l[1])
				touchLru[7 + 3*g] = ~l[0];
			else
				touchLru[8 + 3*g] = ~l[0];
		end
	endfunction

	// address compare, masks only on lines 10 and 11
	always @* begin
		hitVec = 16'h0000;
		for (n = 0; n < 16; n = n + 1) begin
			hitVec[n] = validQ[n] & lineHit(lineTag[n], cpuAddr[23:4],
				(n == 10) ? maskAQ : ((n == 11) ? maskBQ : 11'h000));
		end
	end

	// victim choice from the oldest quarter, else the lowest-numbered eligible line, skipping locked and wrong-type lines
	always @* begin
		case (dcszQ)
			2'h1:    resvVec = 16'h8000;
			2'h2:    resvVec = 16'hc000;
			2'h3:    resvVec = 16'hf000;
			default: resvVec = 16'h0000;
		endcase
		eligVec = (cpuFetch ? ~resvVec : resvVec) & ~(validQ & lockQ);
		if (lruQ[0] & lruQ[1] & lruQ[2])
			oldGrp = 2'h0;
		else if (~lruQ[0] & lruQ[3] & lruQ[4])
			oldGrp = 2'h1;
		else if (~lruQ[1] & ~lruQ[3] & lruQ[5])
			oldGrp = 2'h2;
		else
			oldGrp = 2'h3;
		grpTree = lruQ[6 + 3*oldGrp +: 3];
		prefVic = {oldGrp, grpTree[0], grpTree[0] ? grpTree[2] : grpTree[1]};
		grpPick = firstOne(eligVec & (16'h000f << {oldGrp, 2'b00}));
		anyPick = firstOne(eligVec);
		vicAny  = anyPick[4];
		if (eligVec[prefVic])
			vicIdx = prefVic;
		else if (grpPick[4])
			vicIdx = grpPick[3:0];
		else
			vicIdx = anyPick[3:0];
	end

	task startFlash;
		input [1:0]  k;
		input [27:0] blk;
		begin
			stateQ    <= ST_FLASH;
			kindQ     <= k;
			flashReq  <= 1'b1;
			flashAddr <= {blk, 4'h0};
			cntQ      <= waitQ;
		end
	endtask

	task queuePrefetch;
		begin
			if (cpuFetch && prefOn && !(pfValidQ && pfBlockQ == cpuBlock + 28'h1)
				&& !(pfBusy && flashAddr[31:4] == cpuBlock + 28'h1)) begin
				pfStartQ <= 1'b1;
				pfNextQ  <= cpuBlock + 28'h1;
			end
		end
	endtask

	task serveHit;
		begin
			cpuAck   <= 1'b1;
			cpuRdata <= wordOf(lineData[hitIdx], cpuAddr[3:2]);
			hitCntQ  <= hitCntQ + 32'h1;
			lruQ     <= touchLru(lruQ, hitIdx);
			queuePrefetch;
		end
	endtask

	task fillVictim;
		input [127:0] d;
		input [19:0]  tag;
		begin
			if (vicAny) begin
				lineData[vicIdx] <= d;
				lineTag[vicIdx]  <= tag;
				validQ[vicIdx]   <= 1'b1;
				lockQ[vicIdx]    <= 1'b0;
				typeQ[vicIdx]    <= cpuFetch;
				lruQ             <= touchLru(lruQ, vicIdx);
			end
		end
	endtask

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitQ        <= `FPC_WS_RST;
			prefEnQ      <= 2'h0;
			dcszQ        <= 2'h0;
			accIdxQ      <= 4'h0;
			tagWenQ      <= 1'b0;
			for (r = 0; r < 16; r = r + 1)
				lineTag[r] <= 20'h00000;
			validQ       <= 16'h0000;
			lockQ        <= 16'h0000;
			typeQ        <= 16'hffff;
			maskAQ       <= 11'h000;
			maskBQ       <= 11'h000;
			lruQ         <= `FPC_LRU_RST;
			hitCntQ      <= 32'h00000000;
			missCntQ     <= 32'h00000000;
			abtCntQ      <= 32'h00000000;
			stateQ       <= ST_IDLE;
			kindQ        <= `FPC_K_MISS;
			cntQ         <= 3'h0;
			preloadPendQ <= 1'b0;
			plIdxQ       <= 4'h0;
			pfValidQ     <= 1'b0;
			pfBlockQ     <= 28'h0000000;
			pfDataQ      <= 128'h0;
			pfStartQ     <= 1'b0;
			pfNextQ      <= 28'h0000000;
			cpuAck       <= 1'b0;
			cpuRdata     <= 32'h00000000;
			preloadAck   <= 1'b0;
			flashReq     <= 1'b0;
			flashAddr    <= 32'h00000000;
		end else begin
			cpuAck     <= 1'b0;
			preloadAck <= 1'b0;
			case (stateQ)
				ST_IDLE: begin
					if (preloadPendQ) begin
						pfStartQ <= 1'b0;
						startFlash(`FPC_K_PRELOAD, {8'h00, lineTag[plIdxQ]});
					end else if (accept) begin
						if (!cpuCacheable) begin
							startFlash(`FPC_K_BYPASS, cpuBlock);
						end else if (hitAny) begin
							serveHit;
						end else if (cpuFetch && pfValidQ && pfBlockQ == cpuBlock) begin
							cpuAck   <= 1'b1;
							cpuRdata <= wordOf(pfDataQ, cpuAddr[3:2]);
							missCntQ <= missCntQ + 32'h1;
							pfValidQ <= 1'b0;
							fillVictim(pfDataQ, pfBlockQ[19:0]);
							queuePrefetch;
						end else begin
							if (cpuFetch)
								missCntQ <= missCntQ + 32'h1;
							startFlash(`FPC_K_MISS, cpuBlock);
						end
					end else if (pfStartQ) begin
						pfStartQ <= 1'b0;
						startFlash(`FPC_K_PREF, pfNextQ);
					end
				end
				ST_FLASH: begin
					if (pfBusy && (preloadPendQ || cpuStore || (accept &&
						!(cpuFetch && cpuCacheable && (hitAny || cpuBlock == flashAddr[31:4]))))) begin
						flashReq <= 1'b0;
						stateQ   <= ST_IDLE;
						if (!preloadPendQ)
							abtCntQ <= abtCntQ + 32'h1;
					end else begin
						if (pfBusy && accept && cpuFetch && cpuCacheable && hitAny)
							serveHit;
						if (cntQ != 3'h0) begin
							cntQ <= cntQ - 3'h1;
						end else begin
							flashReq <= 1'b0;
							stateQ   <= ST_IDLE;
							case (kindQ)
								`FPC_K_MISS: begin
									cpuAck   <= 1'b1;
									cpuRdata <= wordOf(flashRdata, cpuAddr[3:2]);
									fillVictim(flashRdata, flashAddr[23:4]);
									queuePrefetch;
								end
								`FPC_K_BYPASS: begin
									cpuAck   <= 1'b1;
									cpuRdata <= wordOf(flashRdata, cpuAddr[3:2]);
								end
								`FPC_K_PREF: begin
									pfDataQ  <= flashRdata;
									pfValidQ <= 1'b1;
									pfBlockQ <= flashAddr[31:4];
								end
								default: begin
									lineData[plIdxQ] <= flashRdata;
									validQ[plIdxQ]   <= 1'b1;
									preloadPendQ     <= 1'b0;
								end
							endcase
						end
					end
				end
				default: begin
					stateQ   <= ST_IDLE;
					flashReq <= 1'b0;
				end
			endcase

			// software writes land last so they win over same-cycle updates
			if (regWr) begin
				case (regAddr)
					`FPC_OFF_CTRL: begin
						waitQ   <= regWdata[`FPC_WS_MSB:`FPC_WS_LSB];
						prefEnQ <= regWdata[`FPC_PREF_MSB:`FPC_PREF_LSB];
						dcszQ   <= regWdata[`FPC_DATA_LINE_ALLOCATION_MSB:`FPC_DATA_LINE_ALLOCATION_LSB];
					end
					`FPC_OFF_ACC: begin
						accIdxQ <= regWdata[`FPC_IDX_MSB:`FPC_IDX_LSB];
						tagWenQ <= regWdata[`FPC_WEN_BIT];
					end
					`FPC_OFF_TAG: begin
						if (tagWenQ) begin
							lineTag[accIdxQ] <= regWdata[`FPC_TAG_MSB:`FPC_TAG_LSB];
							validQ[accIdxQ]  <= regWdata[`FPC_VALID_BIT];
							lockQ[accIdxQ]   <= regWdata[`FPC_LOCK_BIT];
							typeQ[accIdxQ]   <= regWdata[`FPC_TYPE_BIT];
							if (!regWdata[`FPC_VALID_BIT] && regWdata[`FPC_LOCK_BIT]) begin
								preloadPendQ <= 1'b1;
								plIdxQ       <= accIdxQ;
								preloadAck   <= 1'b1;
							end
						end
					end
					`FPC_OFF_MASK: begin
						if (accIdxQ == `FPC_MASK_LINE_A)
							maskAQ <= regWdata[`FPC_MASK_MSB:`FPC_MASK_LSB];
						else if (accIdxQ == `FPC_MASK_LINE_B)
							maskBQ <= regWdata[`FPC_MASK_MSB:`FPC_MASK_LSB];
					end
					`FPC_OFF_HIT:  hitCntQ  <= regWdata;
					`FPC_OFF_MISS: missCntQ <= regWdata;
					`FPC_OFF_ABT:  abtCntQ  <= regWdata;
					default: ;
				endcase
			end
		end
	end

	// read data stand only in the cycle after the read strobe
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 32'h00000000;
		end else if (regRd) begin
			if (regAddr[7:4] == `FPC_OFF_WORDS && regAddr[1:0] == 2'b00) begin
				regRdata <= wordOf(lineData[accIdxQ], regAddr[3:2]);
			end else begin
				case (regAddr)
					`FPC_OFF_CTRL: regRdata <= {22'h0, dcszQ, 2'h0, prefEnQ, 1'b0, waitQ};
					`FPC_OFF_ACC:  regRdata <= {tagWenQ, 27'h0, accIdxQ};
					`FPC_OFF_TAG:  regRdata <= {8'h00, lineTag[accIdxQ], validQ[accIdxQ],
						lockQ[accIdxQ], typeQ[accIdxQ], 1'b0};
					`FPC_OFF_MASK: regRdata <= {16'h0000,
						(accIdxQ == `FPC_MASK_LINE_A) ? maskAQ :
						((accIdxQ == `FPC_MASK_LINE_B) ? maskBQ : 11'h000), 5'h00};
					`FPC_OFF_LRU:  regRdata <= {7'h00, lruQ};
					`FPC_OFF_HIT:  regRdata <= hitCntQ;
					`FPC_OFF_MISS: regRdata <= missCntQ;
					`FPC_OFF_ABT:  regRdata <= abtCntQ;
					default:       regRdata <= 32'h00000000;
				endcase
			end
		end else begin
			regRdata <= 32'h00000000;
		end
	end

endmodule
`default_nettype wire

// File: common/fpc_map.vh
`ifndef FPC_MAP_VH
`define FPC_MAP_VH

// register offsets (byte addresses on the register port; FPC_OFF_WORDS gives only the upper nibble of the line-word window)
`define FPC_OFF_CTRL      8'h00
`define FPC_OFF_ACC       8'h04
`define FPC_OFF_TAG       8'h08
`define FPC_OFF_MASK      8'h0c
`define FPC_OFF_WORDS     4'h1
`define FPC_OFF_LRU       8'h20
`define FPC_OFF_HIT       8'h24
`define FPC_OFF_MISS      8'h28
`define FPC_OFF_ABT       8'h2c

// cache_control_reg fields
`define FPC_WS_MSB        2
`define FPC_WS_LSB        0
`define FPC_PREF_MSB      5
`define FPC_PREF_LSB      4
`define FPC_DATA_LINE_ALLOCATION_MSB      9
`define FPC_DATA_LINE_ALLOCATION_LSB      8

// cache_access_reg fields
`define FPC_IDX_MSB       3
`define FPC_IDX_LSB       0
`define FPC_WEN_BIT       31

// line_tag_reg fields
`define FPC_TAG_MSB       23
`define FPC_TAG_LSB       4
`define FPC_VALID_BIT     3
`define FPC_LOCK_BIT      2
`define FPC_TYPE_BIT      1

// line_mask_reg field
`define FPC_MASK_MSB      15
`define FPC_MASK_LSB      5

// lines that honour an address mask
`define FPC_MASK_LINE_A   4'ha
`define FPC_MASK_LINE_B   4'hb

// reset values
`define FPC_WS_RST        3'h7
`define FPC_LRU_RST       25'h000003f

// flash access kinds
`define FPC_K_MISS        2'h0
`define FPC_K_BYPASS      2'h1
`define FPC_K_PREF        2'h2
`define FPC_K_PRELOAD     2'h3

`endif

// File: tb/fpc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model (
	input  wire logic         ref_clk,
	input  wire logic         flashReq,
	input  wire logic [31:0]  flashAddr,
	output var  logic [127:0] flashRdata
);
	logic [31:0] junk = 32'h1;
	// lines carry a changing pattern while not read
	always @(posedge ref_clk) begin
		junk <= {junk[30:0], junk[31] ^ junk[21]};
	end
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			flashRdata[32*k +: 32] = flashReq ? (flashAddr + 32'(4*k)) ^ 32'h5a5a0000 : junk ^ 32'(k);
		end
	end
endmodule
`default_nettype wire

// File: tb/fpc_cache_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_cache_assertions (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic        cpuAck,
	input wire logic        cpuStall,
	input wire logic        preloadAck,
	input wire logic        flashReq,
	input wire logic [31:0] flashAddr
);
	logic        wen_q;
	logic [19:0] tag_q;
	logic [2:0]  ws_q;
	logic        pref_q;
	logic [3:0]  run_q;
	wire         plWr = regWr && regAddr == 8'h08 && wen_q && regWdata[3:2] == 2'b01;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wen_q <= 1'b0;
			tag_q <= 20'h0;
			ws_q <= 3'h7;
			pref_q <= 1'b0;
			run_q <= 4'h0;
		end else begin
			if (regWr && regAddr == 8'h04)
				wen_q <= regWdata[31];
			if (plWr)
				tag_q <= regWdata[23:4];
			if (regWr && regAddr == 8'h00) begin
				ws_q <= regWdata[2:0];
				pref_q <= |regWdata[5:4];
			end
			run_q <= flashReq ? run_q + 4'h1 : 4'h0;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_FLASH_ALIGN: assert property (flashReq |-> flashAddr[3:0] == 4'h0)
		else $error("flash address not aligned");
	AST_PRELOAD_ACK: assert property (preloadAck == $past(plWr))
		else $error("preload acknowledge wrong");
	AST_STALL_ON_PRELOAD: assert property (preloadAck |-> cpuStall)
		else $error("no stall on preload");
	AST_PRELOAD_READ: assert property (preloadAck |-> ##[0:20] (flashReq && flashAddr[23:4] == tag_q))
		else $error("preload read missing");
	AST_STALL_BOUND: assert property (cpuStall |-> ##[1:40] !cpuStall)
		else $error("stall never released");
	AST_FLASH_SPAN: assert property (flashReq |-> run_q <= {1'b0, ws_q})
		else $error("flash access too long");
	AST_MISS_ANSWER: assert property (cpuAck && !pref_q && $past(flashReq) |-> $past(run_q) == {1'b0, ws_q})
		else $error("miss answer timing wrong");
	AST_ACK_PULSE: assert property (cpuAck |=> !cpuAck)
		else $error("answer longer than a cycle");
	AST_LRU_RESERVED: assert property ($past(regRd) && $past(regAddr) == 8'h20 |-> regRdata[31:25] == 7'h0)
		else $error("replacement state upper bits set");
	cover property (preloadAck);
	cover property (cpuAck && $past(flashReq));
	cover property ($fell(cpuStall));
endmodule
bind fpc_cache fpc_cache_assertions i_fpc_cache_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.cpuAck(cpuAck), .cpuStall(cpuStall), .preloadAck(preloadAck), .flashReq(flashReq),
	.flashAddr(flashAddr));
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic         ref_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [7:0]   regAddr = 8'h0;
	logic [31:0]  regWdata = 32'h0;
	logic         regWr = 1'b0;
	logic         regRd = 1'b0;
	logic         cpuReq = 1'b0;
	logic [31:0]  cpuAddr = 32'h0;
	logic         cpuCacheable = 1'b1;
	logic         cpuFetch = 1'b1;
	logic         cpuStore = 1'b0;
	wire  [31:0]  regRdata;
	wire  [31:0]  cpuRdata;
	wire  [31:0]  flashAddr;
	wire  [127:0] flashRdata;
	wire          cpuAck;
	wire          cpuStall;
	wire          preloadAck;
	wire          flashReq;
	int           failures = 0;
	int           testsRun = 0;
	int           plCnt = 0;
	logic [31:0]  seed = 32'hcb122af4;
	always #10 ref_clk = ~ref_clk;
	fpc_cache i_fpc_cache (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuFetch(cpuFetch), .cpuCacheable(cpuCacheable),
		.cpuStore(cpuStore), .cpuAck(cpuAck), .cpuRdata(cpuRdata), .cpuStall(cpuStall),
		.preloadAck(preloadAck), .flashReq(flashReq), .flashAddr(flashAddr),
		.flashRdata(flashRdata));
	fpc_flash_model i_fpc_flash_model (.ref_clk(ref_clk), .flashReq(flashReq),
		.flashAddr(flashAddr), .flashRdata(flashRdata));
	always @(posedge ref_clk) begin
		if (preloadAck === 1'b1)
			plCnt++;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] ew(input logic [31:0] a);
		return {a[31:2], 2'b00} ^ 32'h5a5a0000;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		testsRun++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk) begin
			regAddr <= a;
			regWdata <= d;
			regWr <= 1'b1;
		end
		@(posedge ref_clk) regWr <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk) begin
			regAddr <= a;
			regRd <= 1'b1;
		end
		@(posedge ref_clk) regRd <= 1'b0;
		@(negedge ref_clk) chk(regRdata, e);
	endtask
	// one processor access; latency counted in clock cycles (falling edges) after launch
	task automatic fx(input logic [31:0] a, input logic c, input int lat);
		int n;
		n = 0;
		@(posedge ref_clk) begin
			cpuReq <= 1'b1;
			cpuAddr <= a;
			cpuCacheable <= c;
		end
		do begin
			@(negedge ref_clk);
			n++;
		end while (cpuAck !== 1'b1 && n < 200);
		@(posedge ref_clk) cpuReq <= 1'b0;
		chk(cpuRdata, ew(a));
		chk(32'(n), 32'(lat));
	endtask
	task automatic stop_test;
		if (failures == 0 && testsRun > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		stop_test();
	end
	initial begin
		logic [31:0] a;
		logic [31:0] r;
		logic [2:0]  ws;
		logic        c;
		logic        hit;
		int          hits;
		int          miss;
		bit          seen [8];
		hits = 0;
		miss = 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdchk(8'h20, 32'h3f);
		for (int i = 0; i < 3; i++)
			rdchk(8'(8'h24 + 4 * i), 32'h0);
		rdchk(8'h00, 32'h7);
		rdchk(8'h30, 32'h0);
		for (int k = 0; k < 4; k++) begin
			ws = 3'(rnd());
			wr(8'h00, {29'h0, ws});
			repeat (12) begin
				// four blocks fit one per group, so no fill can evict a cached block
				a = 32'h00010000 | (rnd() & 32'h3c);
				r = rnd();
				c = r[0] | r[1];
				hit = c && seen[a[6:4]];
				fx(a, c, hit ? 2 : 32'(ws) + 3);
				if (hit)
					hits++;
				else if (c)
					miss++;
				if (c)
					seen[a[6:4]] = 1'b1;
			end
		end
		rdchk(8'h24, 32'(hits));
		rdchk(8'h28, 32'(miss));
		fx(32'h00010080, 1'b1, 32'(ws) + 3);
		wr(8'h24, 32'hffffffff);
		fx(32'h00010084, 1'b1, 2);
		rdchk(8'h24, 32'h0);
		wr(8'h28, 32'h12345678);
		rdchk(8'h28, 32'h12345678);
		wr(8'h04, 32'h80000003);
		wr(8'h0c, 32'hffff);
		rdchk(8'h0c, 32'h0);
		wr(8'h04, 32'h8000000a);
		wr(8'h0c, 32'hffff);
		rdchk(8'h0c, 32'hffe0);
		wr(8'h0c, 32'h0);
		@(negedge ref_clk) r = 32'h0;
		wr(8'h20, 32'h0);
		wr(8'h04, 32'h5);
		wr(8'h08, 32'h00023456);
		chk(32'(plCnt), 32'h0);
		wr(8'h04, 32'h80000005);
		wr(8'h08, 32'h00023456);
		@(negedge ref_clk);
		for (int i = 0; i < 60 && cpuStall === 1'b1; i++)
			@(negedge ref_clk);
		chk(32'(plCnt), 32'h1);
		rdchk(8'h08, 32'h0002345e);
		fx(32'h00023458, 1'b1, 2);
		fx(32'h00040000, 1'b1, 32'(ws) + 3);
		// data loads with line 15 reserved for data
		wr(8'h00, 32'h107);
		@(posedge ref_clk) cpuFetch <= 1'b0;
		fx(32'h00070000, 1'b1, 10);
		fx(32'h00070008, 1'b1, 2);
		@(posedge ref_clk) cpuFetch <= 1'b1;
		rdchk(8'h24, 32'h2);
		rdchk(8'h28, 32'h12345679);
		wr(8'h00, 32'h17);
		rdchk(8'h2c, 32'h0);
		fx(32'h00050000, 1'b1, 10);
		@(posedge ref_clk) cpuStore <= 1'b1;
		@(posedge ref_clk) cpuStore <= 1'b0;
		rdchk(8'h2c, 32'h1);
		fx(32'h00060000, 1'b1, 10);
		repeat (20) @(posedge ref_clk);
		fx(32'h00060014, 1'b1, 2);
		stop_test();
	end
endmodule
`default_nettype wire
